// *** core/usbrp_port2.sv ***
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module usbrp_port2 #(
	parameter int RESET_CYCLES = usbrp_pkg::RST_CYCLES
) (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// AXI4-Lite write address and data
	input  wire logic                       awvalid_i,
	output logic                            awready_o,
	input  wire logic [usbrp_pkg::ADDR_W-1:0] awaddr_i,
	input  wire logic                       wvalid_i,
	output logic                            wready_o,
	input  wire logic [31:0]                wdata_i,
	input  wire logic [3:0]                 wstrb_i,
	// AXI4-Lite write response
	output logic                            bvalid_o,
	input  wire logic                       bready_i,
	output logic [1:0]                      bresp_o,
	// AXI4-Lite read
	input  wire logic                       arvalid_i,
	output logic                            arready_o,
	input  wire logic [usbrp_pkg::ADDR_W-1:0] araddr_i,
	output logic                            rvalid_o,
	input  wire logic                       rready_i,
	output logic [31:0]                     rdata_o,
	output logic [1:0]                      rresp_o,
	// Port side
	input  wire logic                       connect_i,
	output logic                            usb_reset_o,
	// Interrupt
	output logic                            irq_o
);
	// ----------------------------------------
	// Connect pin synchroniser
	// ----------------------------------------
	logic conn_meta_q, conn_q, conn_prev_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conn_meta_q <= 1'b0;
			conn_q      <= 1'b0;
			conn_prev_q <= 1'b0;
		end else begin
			conn_meta_q <= connect_i;
			conn_q      <= conn_meta_q;
			conn_prev_q <= conn_q;
		end
	end

	// ----------------------------------------
	// Write channel capture
	// ----------------------------------------
	logic                          aw_v_q, aw_v_d, w_v_q, w_v_d;
	logic [usbrp_pkg::ADDR_W-1:0]  aw_a_q, aw_a_d;
	logic [31:0]                   w_d_q, w_d_d;
	logic [3:0]                    w_s_q, w_s_d;
	logic                          awready_q, awready_d;
	logic                          wready_q, wready_d;
	logic                          bvalid_q, bvalid_d;
	logic [1:0]                    bresp_q, bresp_d;
	logic                          wr_go;
	logic [31:0]                   wmask, port_wm, clr_wm, en_wm;

	// Write acts once both halves are held and no response is pending
	assign wr_go = aw_v_q & w_v_q & ~bvalid_q;

	always_comb begin
		wmask = {{8{w_s_q[3]}}, {8{w_s_q[2]}},
			{8{w_s_q[1]}}, {8{w_s_q[0]}}} & w_d_q;
		port_wm = (wr_go && aw_a_q == usbrp_pkg::PORT_OFS) ? wmask : 32'h0;
		clr_wm  = (wr_go && aw_a_q == usbrp_pkg::ICLR_OFS) ? wmask : 32'h0;
		en_wm   = (wr_go && aw_a_q == usbrp_pkg::IEN_OFS) ? wmask : 32'h0;
	end

	always_comb begin
		aw_v_d   = aw_v_q;
		aw_a_d   = aw_a_q;
		w_v_d    = w_v_q;
		w_d_d    = w_d_q;
		w_s_d    = w_s_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		if (awvalid_i && awready_q) begin
			aw_v_d = 1'b1;
			aw_a_d = awaddr_i;
		end
		if (wvalid_i && wready_q) begin
			w_v_d = 1'b1;
			w_d_d = wdata_i;
			w_s_d = wstrb_i;
		end
		if (bvalid_q && bready_i) begin
			bvalid_d = 1'b0;
		end
		if (wr_go) begin
			aw_v_d   = 1'b0;
			w_v_d    = 1'b0;
			bvalid_d = 1'b1;
			if (aw_a_q == usbrp_pkg::PORT_OFS ||
				aw_a_q == usbrp_pkg::ICLR_OFS ||
				aw_a_q == usbrp_pkg::IEN_OFS) begin
				bresp_d = usbrp_pkg::RESP_OK;
			end else begin
				bresp_d = usbrp_pkg::RESP_ERR;
			end
		end
		awready_d = ~aw_v_d & ~bvalid_d;
		wready_d  = ~w_v_d & ~bvalid_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_v_q    <= 1'b0;
			aw_a_q    <= '0;
			w_v_q     <= 1'b0;
			w_d_q     <= 32'h0;
			w_s_q     <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= usbrp_pkg::RESP_OK;
		end else begin
			aw_v_q    <= aw_v_d;
			aw_a_q    <= aw_a_d;
			w_v_q     <= w_v_d;
			w_d_q     <= w_d_d;
			w_s_q     <= w_s_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ----------------------------------------
	// Port state and reset signalling
	// ----------------------------------------
	usbrp_pkg::usbrp_port_type      port_q, port_d;
	usbrp_pkg::usbrp_rst_state_type st_q, st_d;
	logic [usbrp_pkg::CNT_W-1:0]    cnt_q, cnt_d;
	logic                           rst_done, set_cmd;
	logic                           drive_q, drive_d;

	assign rst_done = (st_q == usbrp_pkg::RST_DRIVE) &&
		(cnt_q == '0);
	assign set_cmd  = port_wm[usbrp_pkg::RST_BIT] |
		port_wm[usbrp_pkg::ENA_BIT] | port_wm[usbrp_pkg::SUSP_BIT];

	always_comb begin
		port_d = port_q;
		st_d   = st_q;
		cnt_d  = cnt_q;
		// Power is a record only; it reaches no pin
		if (port_wm[usbrp_pkg::PWR_BIT]) begin
			port_d.power = 1'b1;
		end else if (port_wm[usbrp_pkg::PCLR_BIT]) begin
			port_d.power = 1'b0;
		end
		// Clear first so that a same-cycle event wins
		if (port_wm[usbrp_pkg::CSC_BIT]) begin
			port_d.connect_state_changed = 1'b0;
		end
		if (port_wm[usbrp_pkg::RESET_STATE_CHANGED_BIT]) begin
			port_d.reset_state_changed = 1'b0;
		end
		if (conn_q != conn_prev_q) begin
			port_d.connect_state_changed = 1'b1;
		end
		if (set_cmd && !conn_q) begin
			port_d.connect_state_changed = 1'b1;
		end
		case (st_q)
			usbrp_pkg::RST_IDLE: begin
				// Only a one starts reset; zeros pass by
				if (port_wm[usbrp_pkg::RST_BIT] && conn_q) begin
					st_d  = usbrp_pkg::RST_DRIVE;
					cnt_d = usbrp_pkg::CNT_W'(RESET_CYCLES - 1);
				end
			end
			usbrp_pkg::RST_DRIVE: begin
				if (rst_done) begin
					st_d        = usbrp_pkg::RST_IDLE;
					port_d.reset_state_changed = 1'b1;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				st_d = usbrp_pkg::RST_IDLE;
			end
		endcase
		// Pin gets its own flop so no decode sits on the output
		drive_d = (st_d == usbrp_pkg::RST_DRIVE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_q  <= usbrp_pkg::PORT_RESET;
			st_q    <= usbrp_pkg::RST_IDLE;
			cnt_q   <= '0;
			drive_q <= 1'b0;
		end else begin
			port_q  <= port_d;
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			drive_q <= drive_d;
		end
	end

	// Reset pin mirrors the drive state from a flop
	assign usb_reset_o = drive_q;

	// ----------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------
	logic [usbrp_pkg::IRQ_W-1:0] ists_q, ists_d, ien_q, ien_d;
	logic                        irq_q, irq_d;

	always_comb begin
		ists_d = ists_q & ~clr_wm[usbrp_pkg::IRQ_W-1:0];
		ien_d  = ien_q;
		if (wr_go && aw_a_q == usbrp_pkg::IEN_OFS) begin
			ien_d = en_wm[usbrp_pkg::IRQ_W-1:0];
		end
		if (rst_done) begin
			ists_d[usbrp_pkg::IRQ_RESET_STATE_CHANGED] = 1'b1;
		end
		if (!port_q.connect_state_changed && port_d.connect_state_changed) begin
			ists_d[usbrp_pkg::IRQ_CSC] = 1'b1;
		end
		irq_d = |(ists_d & ien_d);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ists_q <= '0;
			ien_q  <= '0;
			irq_q  <= 1'b0;
		end else begin
			ists_q <= ists_d;
			ien_q  <= ien_d;
			irq_q  <= irq_d;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d, port_rd;
	logic [1:0]  rresp_q, rresp_d;

	always_comb begin
		port_rd = 32'h0;
		port_rd[usbrp_pkg::CONN_BIT] = conn_q;
		port_rd[usbrp_pkg::RST_BIT]  = usb_reset_o;
		port_rd[usbrp_pkg::PWR_BIT]  = port_q.power;
		port_rd[usbrp_pkg::CSC_BIT]  = port_q.connect_state_changed;
		port_rd[usbrp_pkg::RESET_STATE_CHANGED_BIT] = port_q.reset_state_changed;
	end

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q && rready_i) begin
			rvalid_d = 1'b0;
		end
		if (arvalid_i && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = usbrp_pkg::RESP_OK;
			rdata_d  = 32'h0;
			if (araddr_i == usbrp_pkg::PORT_OFS) begin
				rdata_d = port_rd;
			end else if (araddr_i == usbrp_pkg::ISTS_OFS) begin
				rdata_d[usbrp_pkg::IRQ_W-1:0] = ists_q;
			end else if (araddr_i == usbrp_pkg::IEN_OFS) begin
				rdata_d[usbrp_pkg::IRQ_W-1:0] = ien_q;
			end else if (araddr_i != usbrp_pkg::ICLR_OFS) begin
				rresp_d = usbrp_pkg::RESP_ERR;
			end
		end
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= usbrp_pkg::RESP_OK;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	assign awready_o = awready_q;
	assign wready_o  = wready_q;
	assign bvalid_o  = bvalid_q;
	assign bresp_o   = bresp_q;
	assign arready_o = arready_q;
	assign rvalid_o  = rvalid_q;
	assign rdata_o   = rdata_q;
	assign rresp_o   = rresp_q;
	assign irq_o     = irq_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_power_set_one: assert property (@(posedge clk_i) disable iff (rst_i)
		port_wm[usbrp_pkg::PWR_BIT] |=> port_q.power)
		else $error("power bit not set by write of one");
	a_power_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		!port_wm[usbrp_pkg::PWR_BIT] && !port_wm[usbrp_pkg::PCLR_BIT]
		|=> $stable(port_q.power))
		else $error("power bit changed without a write of one");
	a_reset_start: assert property (@(posedge clk_i) disable iff (rst_i)
		port_wm[usbrp_pkg::RST_BIT] && conn_q && !usb_reset_o
		|=> usb_reset_o)
		else $error("reset signalling did not start");
	a_reset_zero_ign: assert property (@(posedge clk_i) disable iff (rst_i)
		!usb_reset_o && !port_wm[usbrp_pkg::RST_BIT] |=> !usb_reset_o)
		else $error("reset started without a write of one");
	a_reset_end_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(usb_reset_o) |-> port_q.reset_state_changed && ists_q[usbrp_pkg::IRQ_RESET_STATE_CHANGED])
		else $error("reset end did not raise change flag");
	a_reset_state_changed_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		port_wm[usbrp_pkg::RESET_STATE_CHANGED_BIT] && !rst_done |=> !port_q.reset_state_changed)
		else $error("reset change flag not cleared by one");
	a_nocon_csc: assert property (@(posedge clk_i) disable iff (rst_i)
		port_wm[usbrp_pkg::RST_BIT] && !conn_q && !usb_reset_o
		|=> port_q.connect_state_changed && !usb_reset_o)
		else $error("disconnected reset write not turned into flag");
	a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		rvalid_o |->
		rdata_o[usbrp_pkg::RSVD_HI:usbrp_pkg::RSVD_LO] == 3'h0)
		else $error("reserved bits read nonzero");
	a_ovc_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		rvalid_o |-> !rdata_o[usbrp_pkg::OVC_BIT])
		else $error("overcurrent bit read as set");
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(ists_q & ien_q))
		else $error("interrupt level does not follow status");
endmodule : usbrp_port2

// *** inc/usbrp_pkg.sv ***
package usbrp_pkg;
	// ----------------------------------------
	// Bus geometry and register map
	// ----------------------------------------
	localparam int          ADDR_W   = 5;
	localparam logic [4:0]  PORT_OFS = 5'h00;
	localparam logic [4:0]  ISTS_OFS = 5'h04;
	localparam logic [4:0]  ICLR_OFS = 5'h08;
	localparam logic [4:0]  IEN_OFS  = 5'h0C;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	// ----------------------------------------
	// Port register field positions
	// ----------------------------------------
	localparam int CONN_BIT  = 0;
	localparam int ENA_BIT   = 1;
	localparam int SUSP_BIT  = 2;
	localparam int OVC_BIT   = 3;
	localparam int RST_BIT   = 4;
	localparam int PWR_BIT   = 8;
	localparam int PCLR_BIT  = 9;
	localparam int CSC_BIT   = 16;
	localparam int RESET_STATE_CHANGED_BIT  = 20;
	localparam int RSVD_LO   = 5;
	localparam int RSVD_HI   = 7;
	// Interrupt status bits
	localparam int IRQ_RESET_STATE_CHANGED  = 0;
	localparam int IRQ_CSC   = 1;
	localparam int IRQ_W     = 2;
	// ----------------------------------------
	// Reset signalling duration
	// ----------------------------------------
	localparam int CLK_KHZ       = 25000;
	localparam int RST_TIME_MS   = 10;
	localparam int RST_CYCLES    = RST_TIME_MS * CLK_KHZ;
	localparam int CNT_W         = 18;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		RST_IDLE  = 2'h1,
		RST_DRIVE = 2'h2
	} usbrp_rst_state_type;
	typedef struct packed {
		logic power;
		logic connect_state_changed;
		logic reset_state_changed;
	} usbrp_port_type;
	localparam usbrp_port_type PORT_RESET = '{1'b0, 1'b0, 1'b0};
endpackage : usbrp_pkg

// *** verif/usb_root_port_status_control_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module usb_root_port_status_control_tb;
	localparam int RC = 20;
	logic        clk_i = 1'b0, rst_i = 1'b1, attach = 1'b0;
	logic        awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
	logic        arvalid_i = 1'b0, rready_i = 1'b0;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic        connect_i, usb_reset_o, irq_o;
	logic [4:0]  awaddr_i = '0, araddr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, d;
	logic [3:0]  wstrb_i = 4'hF;
	logic [1:0]  bresp_o, rresp_o, r;
	logic        pw;
	int          reset_len, fail_count = 0, comparisons = 0, n;
	always #20 clk_i = ~clk_i;
	usbrp_port2 #(.RESET_CYCLES(RC)) usbrp_port2_i (.clk_i(clk_i),
		.rst_i(rst_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
		.awaddr_i(awaddr_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.wdata_i(wdata_i), .wstrb_i(wstrb_i), .bvalid_o(bvalid_o),
		.bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
		.arready_o(arready_o), .araddr_i(araddr_i), .rvalid_o(rvalid_o),
		.rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
		.connect_i(connect_i), .usb_reset_o(usb_reset_o), .irq_o(irq_o));
	usbrp_dev_model usbrp_dev_model_i (.clk_i(clk_i), .attach_i(attach),
		.usb_reset_i(usb_reset_o), .connect_o(connect_i),
		.reset_len_o(reset_len));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] port_exp(input logic c, rs, p, cs, pc);
		return (32'(c) << usbrp_pkg::CONN_BIT) | (32'(rs) << usbrp_pkg::RST_BIT)
			| (32'(p) << usbrp_pkg::PWR_BIT) | (32'(cs) << usbrp_pkg::CSC_BIT)
			| (32'(pc) << usbrp_pkg::RESET_STATE_CHANGED_BIT);
	endfunction : port_exp
	// Response readies stay high between calls; only the watchdog ends a wait
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		awaddr_i  <= a;
		wdata_i   <= v;
		awvalid_i <= 1'b1;
		wvalid_i  <= 1'b1;
		bready_i  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready_o === 1'b1) awvalid_i <= 1'b0;
			if (wready_o === 1'b1) wvalid_i <= 1'b0;
		end while (bvalid_o !== 1'b1);
		r = bresp_o;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		araddr_i  <= a;
		arvalid_i <= 1'b1;
		rready_i  <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready_o === 1'b1) arvalid_i <= 1'b0;
		end while (rvalid_o !== 1'b1);
		d = rdata_o;
		r = rresp_o;
	endtask : rd
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		finish_test;
	end
	initial begin
		void'($urandom(41503));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, 32'h0000_0000)
		rd(usbrp_pkg::IEN_OFS);
		`CHK(d, 32'h0000_0000)
		$display("test reset values done");
		wr(usbrp_pkg::PORT_OFS, 32'h0000_0010);
		`CHK(usb_reset_o, 1'b0)
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(0, 0, 0, 1, 0))
		wr(usbrp_pkg::PORT_OFS, 32'h0001_0000);
		wr(usbrp_pkg::PORT_OFS, 32'h0000_0006);
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(0, 0, 0, 1, 0))
		wr(usbrp_pkg::PORT_OFS, 32'h0001_0000);
		$display("test disconnected reset done");
		pw = 1'b0;
		for (int i = 0; i < 8; i++) begin
			wr(usbrp_pkg::PORT_OFS, $urandom & 32'h0000_03E8);
			pw = wdata_i[8] | (pw & ~wdata_i[9]);
			rd(usbrp_pkg::PORT_OFS);
			`CHK(d, port_exp(0, 0, pw, 0, 0))
		end
		$display("test power random done");
		wr(5'h10, 32'h0000_0100);
		`CHK(r, usbrp_pkg::RESP_ERR)
		rd(5'h14);
		`CHK(r, usbrp_pkg::RESP_ERR)
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(0, 0, pw, 0, 0))
		$display("test unmapped done");
		attach <= 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		rd(usbrp_pkg::ISTS_OFS);
		`CHK(d, 32'h0000_0002)
		wr(usbrp_pkg::IEN_OFS, 32'h0000_0003);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(usbrp_pkg::ICLR_OFS, 32'h0000_0002);
		wr(usbrp_pkg::PORT_OFS, 32'h0001_0000);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		$display("test attach irq done");
		wr(usbrp_pkg::PORT_OFS, 32'h0000_0010);
		`CHK(usb_reset_o, 1'b1)
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(1, 1, pw, 0, 0))
		wr(usbrp_pkg::PORT_OFS, 32'h0000_0000);
		`CHK(usb_reset_o, 1'b1)
		n = 0;
		while (usb_reset_o === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		repeat (2) @(posedge clk_i);
		`CHK(reset_len, RC)
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(1, 0, pw, 0, 1))
		`CHK(irq_o, 1'b1)
		wr(usbrp_pkg::PORT_OFS, 32'h0010_0000);
		wr(usbrp_pkg::ICLR_OFS, 32'h0000_0001);
		rd(usbrp_pkg::PORT_OFS);
		`CHK(d, port_exp(1, 0, pw, 0, 0))
		`CHK(irq_o, 1'b0)
		$display("test port reset done");
		finish_test;
	end
endmodule : usb_root_port_status_control_tb

// *** verif/usbrp_dev_model.sv ***
`timescale 1ns/100ps
module usbrp_dev_model (
	// Clock
	input  wire logic clk_i,
	// Bench control
	input  wire logic attach_i,
	// Link
	input  wire logic usb_reset_i,
	output logic      connect_o,
	output int        reset_len_o
);
	// ----------------------------------------
	// Attached device
	// ----------------------------------------
	int cnt_q = 0;
	initial reset_len_o = 0;
	// Connect follows the bench's attach request
	assign connect_o = attach_i;
	// Length of each reset burst, latched when it ends
	always @(posedge clk_i) begin
		if (usb_reset_i) begin
			cnt_q <= cnt_q + 1;
		end else if (cnt_q != 0) begin
			reset_len_o <= cnt_q;
			cnt_q       <= 0;
		end
	end
endmodule : usbrp_dev_model
